/* logic/bnvm_consts.vh */
`ifndef BNVM_CONSTS_VH
`define BNVM_CONSTS_VH

// ==========================================================
// geometry
`define BNVM_ADDR_W        13
`define BNVM_DATA_W        8

// ==========================================================
// timing, in ns, and derived cycle counts at 50 MHz
`define BNVM_CLK_PERIOD_NS 20
`define BNVM_ACCESS_NS     70
`define BNVM_CYCLE_NS      130
`define BNVM_PRECHARGE_NS  60
// least times round up
`define BNVM_ACCESS_CYC    ((`BNVM_ACCESS_NS + `BNVM_CLK_PERIOD_NS - 1) / `BNVM_CLK_PERIOD_NS)
`define BNVM_CYCLE_CYC     ((`BNVM_CYCLE_NS + `BNVM_CLK_PERIOD_NS - 1) / `BNVM_CLK_PERIOD_NS)
`define BNVM_PRECHARGE_CYC ((`BNVM_PRECHARGE_NS + `BNVM_CLK_PERIOD_NS - 1) / `BNVM_CLK_PERIOD_NS)
// read byte passes two flops before use
`define BNVM_SYNC_CYC      2

// ==========================================================
// controller states
`define BNVM_ST_IDLE       3'h0
`define BNVM_ST_SETUP      3'h1
`define BNVM_ST_ACCESS     3'h2
`define BNVM_ST_PRECHARGE  3'h3

`endif

/* logic/bnvm_host.v */
// Behaviour
// - 13 address lines select one byte
// - shared 8-bit data bus, both directions
// - every access needs new select fall
// - select high between accesses for precharge
// - reads and writes share one timing
// - 70 ns access, 130 ns cycle
// - write ends first strobe/select rise, data held
// - select high at least precharge time
`timescale 1ns/1ps
`include "bnvm_consts.vh"

module bnvm_host #(
   parameter ACCESS_CYC    = `BNVM_ACCESS_CYC,
   parameter CYCLE_CYC     = `BNVM_CYCLE_CYC,
   parameter PRECHARGE_CYC = `BNVM_PRECHARGE_CYC
) (
   // clock and reset
   input  wire                      mclk_i,
   input  wire                      resetn_i,
   // user request
   input  wire                      req_i,
   input  wire                      req_write_i,
   input  wire [`BNVM_ADDR_W-1:0]   req_addr_i,
   input  wire [`BNVM_DATA_W-1:0]   req_wdata_i,
   output reg                       req_ready_o,
   output reg                       done_o,
   output reg  [`BNVM_DATA_W-1:0]   rdata_o,
   // memory pins
   output reg  [`BNVM_ADDR_W-1:0]   location_lines_o,
   output reg                       chip_sel_n_o,
   output reg                       write_n_o,
   output reg                       out_en_n_o,
   output reg  [`BNVM_DATA_W-1:0]   byte_lines_o,
   output reg                       byte_lines_oe_o,
   input  wire [`BNVM_DATA_W-1:0]   byte_lines_i
);

   // ==========================================================
   // state codes and derived counts
   localparam ST_IDLE      = `BNVM_ST_IDLE;
   localparam ST_SETUP     = `BNVM_ST_SETUP;
   localparam ST_ACCESS    = `BNVM_ST_ACCESS;
   localparam ST_PRECHARGE = `BNVM_ST_PRECHARGE;

   // a deselected part floats its bus, so the byte crosses the sync while select is low
   localparam SYNC_CYC     = `BNVM_SYNC_CYC;
   localparam LOW_CYC      = ACCESS_CYC + SYNC_CYC;

   // precharge length so that the whole cycle reaches the cycle time
   localparam PC_FROM_CYC  = CYCLE_CYC - LOW_CYC;
   localparam PC_CYC       = (PC_FROM_CYC > PRECHARGE_CYC) ? PC_FROM_CYC : PRECHARGE_CYC;

   // ==========================================================
   // count decode, shared by both timed states
   function cnt_last;
      input [7:0] c;
      begin
         cnt_last = (c == 8'h01);
      end
   endfunction

   // ==========================================================
   // pin input synchroniser
   reg  [`BNVM_DATA_W-1:0] data_meta;
   reg  [`BNVM_DATA_W-1:0] data_sync;

   // only the second stage is read, the first may be metastable
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_meta <= {`BNVM_DATA_W{1'b0}};
         data_sync <= {`BNVM_DATA_W{1'b0}};
      end else begin
         data_meta <= byte_lines_i;
         data_sync <= data_meta;
      end
   end

   // ==========================================================
   // access sequencer, state and count
   reg  [2:0] state;
   reg  [7:0] cnt;
   reg  [2:0] next_state;
   reg  [7:0] next_cnt;
   reg        is_write;
   wire       take;
   wire       access_end;
   wire       cycle_end;

   assign take       = (state == ST_IDLE) && req_i && req_ready_o;
   assign access_end = (state == ST_ACCESS) && cnt_last(cnt);
   assign cycle_end  = (state == ST_PRECHARGE) && cnt_last(cnt);

   always @* begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            next_cnt   = LOW_CYC[7:0];
            next_state = ST_ACCESS;
         end
         ST_ACCESS: begin
            if (access_end) begin
               next_cnt   = PC_CYC[7:0];
               next_state = ST_PRECHARGE;
            end else begin
               next_cnt   = cnt - 8'h01;
            end
         end
         ST_PRECHARGE: begin
            if (cycle_end) begin
               next_cnt   = 8'h00;
               next_state = ST_IDLE;
            end else begin
               next_cnt   = cnt - 8'h01;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt   = 8'h00;
         end
      endcase
   end

   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= ST_IDLE;
         cnt   <= 8'h00;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // ==========================================================
   // request capture, address and data pins
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         is_write         <= 1'b0;
         location_lines_o <= {`BNVM_ADDR_W{1'b0}};
         byte_lines_o     <= {`BNVM_DATA_W{1'b0}};
         write_n_o        <= 1'b1;
         byte_lines_oe_o  <= 1'b0;
      end else begin
         if (take) begin
            is_write         <= req_write_i;
            location_lines_o <= req_addr_i;
            byte_lines_o     <= req_wdata_i;
            write_n_o        <= ~req_write_i;
            byte_lines_oe_o  <= req_write_i;
         end
         if (access_end) begin
            write_n_o <= 1'b1;
         end
         if (state == ST_PRECHARGE) begin
            byte_lines_oe_o <= 1'b0;
         end
      end
   end

   // ==========================================================
   // select and output enable
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chip_sel_n_o <= 1'b1;
         out_en_n_o   <= 1'b1;
      end else begin
         case (state)
            ST_SETUP: begin
               chip_sel_n_o <= 1'b0;
               out_en_n_o   <= is_write;
            end
            ST_ACCESS: begin
               if (access_end) begin
                  chip_sel_n_o <= 1'b1;
                  out_en_n_o   <= 1'b1;
               end
            end
            default: begin
               chip_sel_n_o <= 1'b1;
               out_en_n_o   <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // handshake and read result
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_ready_o <= 1'b0;
         done_o      <= 1'b0;
         rdata_o     <= {`BNVM_DATA_W{1'b0}};
      end else begin
         if (access_end && !is_write) begin
            rdata_o <= data_sync;
         end
         done_o <= cycle_end;
         if (take) begin
            req_ready_o <= 1'b0;
         end else if (state == ST_IDLE || cycle_end) begin
            req_ready_o <= 1'b1;
         end
      end
   end

endmodule // bnvm_host

/* sim/bnvm_chk.sv */
`timescale 1ns/1ps
module bnvm_chk (
   input wire logic        mclk_i, resetn_i, chip_sel_n_o, write_n_o, out_en_n_o,
   input wire logic        byte_lines_oe_o, done_o, req_ready_o,
   input wire logic [12:0] location_lines_o,
   input wire logic [7:0]  byte_lines_o
);
   // ==========================================
   // pin sequencing
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   AST_SEL_LOW: assert property ($fell(chip_sel_n_o) |-> !chip_sel_n_o[*6] ##1 chip_sel_n_o)
      else $error("select low time wrong");
   AST_PRECHG: assert property ($rose(chip_sel_n_o) |-> chip_sel_n_o[*3])
      else $error("precharge too short");
   AST_CYCLE: assert property ($fell(chip_sel_n_o) |-> ##1 (!$fell(chip_sel_n_o))[*6])
      else $error("cycle time too short");
   AST_ADDR_SET: assert property ($fell(chip_sel_n_o) |-> $stable(location_lines_o))
      else $error("address moved at select fall");
   AST_WR_DATA: assert property (!write_n_o && !chip_sel_n_o |-> byte_lines_oe_o && $stable(byte_lines_o))
      else $error("write data not held");
   AST_NO_CLASH: assert property (!out_en_n_o && write_n_o |-> !byte_lines_oe_o)
      else $error("host drives during read");
   AST_WE_FIRST: assert property ($fell(write_n_o) |-> chip_sel_n_o)
      else $error("strobe fell while selected");
   AST_DONE: assert property ($fell(chip_sel_n_o) |-> ##[5:12] done_o)
      else $error("access never completed");
   AST_READY: assert property (done_o |-> req_ready_o)
      else $error("not ready at done");
   AST_RD_OE: assert property ($rose(chip_sel_n_o) && $past(write_n_o) |-> !$past(out_en_n_o))
      else $error("read enable dropped before select rose");
endmodule // bnvm_chk

/* sim/bnvm_mem_model.sv */
`timescale 1ns/1ps
module bnvm_mem_model (
   input  wire logic       ce_n_i, we_n_i, oe_n_i,
   input  wire logic [12:0] addr_i,
   input  wire logic [7:0] d_i,
   output logic      [7:0] q_o
);
   // ==========================================
   // 8192 byte array, no clock
   // one byte per location
   logic [7:0]  mem [0:8191];
   logic [12:0] a;
   logic [7:0]  last;
   logic        wr, ok;
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
      q_o = 8'h00; last = 8'h00; ok = 0; wr = 0;
   end
   // latch at fall, strobe low makes a write, cycle always completes
   always @(negedge ce_n_i) begin
      a = addr_i; wr = !we_n_i; ok = 0; #70 ok = 1;
   end
   always @(negedge we_n_i) if (!ce_n_i) wr = 1;
   // first strobe or select rise stores the held byte at once
   always @(posedge ce_n_i or posedge we_n_i) if (wr) begin mem[a] = d_i; wr = 0; end
   // drive only valid read data while selected; released bus shows the inverse
   always @(ce_n_i or oe_n_i or ok or wr or a) begin
      if (!ce_n_i && !oe_n_i && ok && !wr) begin q_o = mem[a]; last = mem[a]; end
      else q_o = ~last;
   end
endmodule // bnvm_mem_model

/* sim/tb_bytewide_nv_memory_port.sv */
`timescale 1ns/1ps
`define CHK(g,e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_bytewide_nv_memory_port;
   logic mclk_i, resetn_i, req_i, req_write_i, req_ready_o, done_o, chip_sel_n_o, write_n_o, out_en_n_o, byte_lines_oe_o;
   logic [12:0] req_addr_i, location_lines_o;
   logic [7:0]  req_wdata_i, rdata_o, byte_lines_o, mq, exp_mem [0:8191];
   int          err_total = 0, checks_done = 0, seed = 32'h2c1c, r;
   // ==========================================
   // design, memory and shared bus
   bnvm_host u_bnvm_host (.mclk_i, .resetn_i, .req_i, .req_write_i, .req_addr_i, .req_wdata_i, .req_ready_o,
      .done_o, .rdata_o, .location_lines_o, .chip_sel_n_o, .write_n_o, .out_en_n_o, .byte_lines_o,
      .byte_lines_oe_o, .byte_lines_i(byte_lines_oe_o ? byte_lines_o : mq));
   bnvm_mem_model u_bnvm_mem_model (.ce_n_i(chip_sel_n_o), .we_n_i(write_n_o), .oe_n_i(out_en_n_o),
      .addr_i(location_lines_o), .d_i(byte_lines_o), .q_o(mq));
   initial begin mclk_i = 0; forever #10 mclk_i = ~mclk_i; end
   function automatic logic [7:0] exp_rd(input logic [12:0] a); return exp_mem[a]; endfunction
   task automatic op(input logic w, input logic [12:0] a, input logic [7:0] d);
      req_i <= 1; req_write_i <= w; req_addr_i <= a; req_wdata_i <= d;
      @(posedge mclk_i);
      while (req_ready_o !== 1'b1) @(posedge mclk_i);
      req_i <= 0;
      @(posedge mclk_i);
      for (int n = 0; n < 40 && done_o !== 1'b1; n++) @(posedge mclk_i);
      `CHK(done_o, 1'b1)
      if (w) exp_mem[a] = d; else `CHK(rdata_o, exp_rd(a))
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin #300000; err_total++; report_and_stop; end
   initial begin
      for (int i = 0; i < 8192; i++) exp_mem[i] = 8'h00;
      resetn_i = 0; req_i = 0; req_write_i = 0; req_addr_i = 13'h0000; req_wdata_i = 8'h00;
      repeat (10) @(posedge mclk_i);
      `CHK(chip_sel_n_o, 1'b1)
      resetn_i <= 1;
      // boundary locations first
      op(1, 13'h0000, 8'hA5); op(1, 13'h1FFF, 8'h5A); op(0, 13'h1FFF, 8'h00); op(0, 13'h0000, 8'h00);
      repeat (80) begin
         r = $random(seed);
         op(r[0], r[20:8] & 13'h100F, r[31:24]);
      end
      // mid-run reset: select idle, stored byte survives
      resetn_i <= 0;
      repeat (2) @(posedge mclk_i);
      `CHK(chip_sel_n_o, 1'b1)
      resetn_i <= 1;
      op(0, 13'h1FFF, 8'h00);
      report_and_stop;
   end
endmodule // tb_bytewide_nv_memory_port
bind bnvm_host bnvm_chk u_bnvm_chk (.*);
